// ==== core/snt_defs.svh ====
/*
  timing, code and layout constants of the single-edge nibble transmitter.
  assumes a 200 MHz system clock; included by bare name.
*/
`ifndef SNT_DEFS_SVH
`define SNT_DEFS_SVH

`define SNT_CLK_NS 5
`define SNT_TICK_NS 3000
`define SNT_INIT_US 1700
`define SNT_NS_PER_US 1000

`define SNT_LOW_TICKS 5
`define SNT_SYNC_TICKS 56
`define SNT_NIB_BASE_TICKS 12
`define SNT_FRAME_TICKS 282

`define SNT_WORD_W 12
`define SNT_FIFO_DEPTH 32
`define SNT_PERIODS 6
`define SNT_PAUSE_IDX 3'h6

`define SNT_CRC_SEED 4'h5
`define SNT_CRC_POLY 4'hd
`define SNT_ZERO_NIB 4'h0
`define SNT_STATUS_NIB 4'h0

`define SNT_CODE_INIT 12'h000
`define SNT_CODE_CLAMP_LO 12'h001
`define SNT_CODE_POS_MIN 12'h002
`define SNT_CODE_POS_MAX 12'hff7
`define SNT_CODE_CLAMP_HI 12'hff8
`define SNT_CODE_RSVD_LO 12'hff9
`define SNT_CODE_SIG_ERR 12'hffa
`define SNT_CODE_DEV_ERR 12'hffb

`endif

// ==== core/snt_pkg.sv ====
/*
  types shared by the transmitter and its testbench.
  assumes snt_defs.svh is on the include path.
*/
package snt_pkg;
  typedef enum {ST_WAIT, ST_LOAD, ST_SEND} snt_state_e;
  typedef logic [11:0] snt_word_t;
  typedef logic [3:0] snt_nib_t;
endpackage

// ==== core/snt_stream_if.sv ====
/*
  valid/ready word stream between the transmitter and its buffer.
  assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface snt_stream_if #(
  parameter int unsigned WIDTH = 12
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== core/snt_fifo.sv ====
/*
  synchronous fifo of WIDTH x DEPTH words with valid/ready on both sides.
  assumes one clock, synchronous active-low reset, DEPTH a power of two.
*/
`timescale 1ns/10ps
module snt_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 32
)(
  input wire logic clk,
  input wire logic resetn,
  snt_stream_if.snk wr,
  snt_stream_if.src rd
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_ff;
  logic [AW-1:0] rdPtr_ff;
  logic [AW:0] count_ff;
  logic full_ff;
  logic doPush;
  logic doPop;

  assign doPush = wr.valid && !full_ff;
  assign doPop = rd.ready && (count_ff != '0);
  assign wr.ready = !full_ff;
  assign rd.valid = (count_ff != '0);
  assign rd.data = mem[rdPtr_ff];

  // storage
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_ff] <= wr.data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
      full_ff <= 1'b0;
    end else begin
      if (doPush) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doPop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      if (doPush && !doPop) begin
        count_ff <= count_ff + 1'b1;
        full_ff <= (count_ff == (AW+1)'(DEPTH - 1));
      end else if (doPop && !doPush) begin
        count_ff <= count_ff - 1'b1;
        full_ff <= 1'b0;
      end
    end
  end
endmodule

// ==== core/snt_tx.sv ====
/*
  single-edge nibble telegram transmitter of a position sensor: maps the
  output value and fault flags to a 12-bit code, buffers it and sends it
  as sync, status, three data, crc and pause periods on one output pin.
  assumes all inputs come from logic on clk and the pin has a pull-up.
*/
`timescale 1ns/10ps
`include "snt_defs.svh"
module snt_tx
  import snt_pkg::*;
#(
  parameter int unsigned TICK_CYC = `SNT_TICK_NS / `SNT_CLK_NS,
  parameter int unsigned INIT_CYC = `SNT_INIT_US * `SNT_NS_PER_US / `SNT_CLK_NS,
  parameter int unsigned FIFO_DEPTH = `SNT_FIFO_DEPTH
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [11:0] outValue,
  input wire logic sampleValid,
  input wire logic deviceFault,
  input wire logic signalFault,
  input wire logic aboveRange,
  input wire logic belowRange,
  input wire logic formatSent,
  output logic sampleReady,
  output logic sentOut,
  output logic sentBusy,
  output logic initDone
);
  localparam int unsigned LOW_CYC = `SNT_LOW_TICKS * TICK_CYC;

  snt_stream_if #(.WIDTH(`SNT_WORD_W)) inStream ();
  snt_stream_if #(.WIDTH(`SNT_WORD_W)) outStream ();

  snt_state_e state_ff;
  logic [15:0] presc_ff;
  logic [7:0] perCnt_ff;
  logic [8:0] frameCnt_ff;
  logic [2:0] perIdx_ff;
  snt_nib_t nib_ff [5];
  snt_word_t lastWord_ff;
  logic [31:0] initCnt_ff;
  logic initDone_ff;
  logic sentOut_ff;
  logic sentBusy_ff;
  logic sampleReady_ff;
  logic tickHit;
  logic periodEnd;
  logic [7:0] perLen;
  snt_word_t loadWord;
  snt_word_t pushCode;

  // one crc step: multiply by x^4 modulo the generator, then add nibble
  function automatic snt_nib_t crcStep(input snt_nib_t crc, input snt_nib_t nib);
    snt_nib_t c;
    c = crc;
    for (int i = 0; i < 4; i++) begin
      c = c[3] ? ({c[2:0], 1'b0} ^ `SNT_CRC_POLY) : {c[2:0], 1'b0};
    end
    return c ^ nib;
  endfunction

  // crc of a 12-bit data word with the trailing zero nibble
  function automatic snt_nib_t crcWord(input snt_word_t w);
    snt_nib_t c;
    c = `SNT_CRC_SEED;
    c = crcStep(c, w[11:8]);
    c = crcStep(c, w[7:4]);
    c = crcStep(c, w[3:0]);
    c = crcStep(c, `SNT_ZERO_NIB);
    return c;
  endfunction

  // code selection with fault priority
  function automatic snt_word_t mapCode(input logic ready, input logic dev,
                                        input logic sig, input logic hi,
                                        input logic lo, input snt_word_t v);
    if (!ready) begin
      return `SNT_CODE_INIT;
    end else if (dev) begin
      return `SNT_CODE_DEV_ERR;
    end else if (sig) begin
      return `SNT_CODE_SIG_ERR;
    end else if (hi || v > `SNT_CODE_POS_MAX) begin
      return `SNT_CODE_CLAMP_HI;
    end else if (lo || v < `SNT_CODE_POS_MIN) begin
      return `SNT_CODE_CLAMP_LO;
    end
    return v;
  endfunction

  assign pushCode = mapCode(initDone_ff, deviceFault, signalFault, aboveRange,
                            belowRange, outValue);
  assign inStream.valid = sampleValid;
  assign inStream.data = pushCode;
  assign outStream.ready = (state_ff == ST_LOAD);
  assign loadWord = outStream.valid ? outStream.data : lastWord_ff;

  snt_fifo #(.WIDTH(`SNT_WORD_W), .DEPTH(FIFO_DEPTH)) sampleBuf (
    .clk(clk),
    .resetn(resetn),
    .wr(inStream),
    .rd(outStream)
  );

  assign tickHit = (presc_ff == 16'(TICK_CYC - 1));

  always_comb begin
    if (perIdx_ff == 3'h0) begin
      perLen = 8'(`SNT_SYNC_TICKS);
    end else if (perIdx_ff < `SNT_PAUSE_IDX) begin
      perLen = 8'(`SNT_NIB_BASE_TICKS) + {4'h0, nib_ff[perIdx_ff - 3'h1]};
    end else begin
      perLen = '0;
    end
  end

  always_comb begin
    if (perIdx_ff == `SNT_PAUSE_IDX) begin
      periodEnd = tickHit && (frameCnt_ff == 9'(`SNT_FRAME_TICKS - 1));
    end else begin
      periodEnd = tickHit && (perCnt_ff == perLen - 8'h1);
    end
  end

  // power-up initialisation timer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      initCnt_ff <= '0;
      initDone_ff <= 1'b0;
    end else if (!initDone_ff) begin
      initCnt_ff <= initCnt_ff + 32'h1;
      initDone_ff <= (initCnt_ff == INIT_CYC - 1);
    end
  end

  // telegram sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= ST_WAIT;
    end else begin
      case (state_ff)
        ST_WAIT: begin
          if (initDone_ff && formatSent) begin
            state_ff <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          state_ff <= ST_SEND;
        end
        ST_SEND: begin
          if (periodEnd && perIdx_ff == `SNT_PAUSE_IDX) begin
            state_ff <= formatSent ? ST_LOAD : ST_WAIT;
          end
        end
        default: begin
          state_ff <= ST_WAIT;
        end
      endcase
    end
  end

  // tick prescaler and period counters
  always_ff @(posedge clk) begin
    if (!resetn) begin
      presc_ff <= '0;
      perCnt_ff <= '0;
      frameCnt_ff <= '0;
      perIdx_ff <= '0;
    end else if (state_ff != ST_SEND) begin
      presc_ff <= '0;
      perCnt_ff <= '0;
      frameCnt_ff <= '0;
      perIdx_ff <= '0;
    end else begin
      presc_ff <= tickHit ? 16'h0 : presc_ff + 16'h1;
      if (tickHit) begin
        frameCnt_ff <= frameCnt_ff + 9'h1;
        if (periodEnd) begin
          perCnt_ff <= '0;
          perIdx_ff <= perIdx_ff + 3'h1;
        end else begin
          perCnt_ff <= perCnt_ff + 8'h1;
        end
      end
    end
  end

  // nibble contents latched once per telegram
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lastWord_ff <= `SNT_CODE_INIT;
      for (int i = 0; i < 5; i++) begin
        nib_ff[i] <= '0;
      end
    end else if (state_ff == ST_LOAD) begin
      lastWord_ff <= loadWord;
      nib_ff[0] <= `SNT_STATUS_NIB;
      nib_ff[1] <= loadWord[11:8];
      nib_ff[2] <= loadWord[7:4];
      nib_ff[3] <= loadWord[3:0];
      nib_ff[4] <= crcWord(loadWord);
    end
  end

  // output pin: low pulse opens every period, then high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sentOut_ff <= 1'b1;
    end else if (state_ff == ST_LOAD) begin
      sentOut_ff <= 1'b0;
    end else if (state_ff == ST_SEND && tickHit) begin
      if (periodEnd) begin
        sentOut_ff <= (perIdx_ff == `SNT_PAUSE_IDX);
      end else begin
        sentOut_ff <= (perCnt_ff + 8'h1 >= 8'(`SNT_LOW_TICKS));
      end
    end else if (state_ff == ST_WAIT) begin
      sentOut_ff <= 1'b1;
    end
  end

  // status outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sentBusy_ff <= 1'b0;
      sampleReady_ff <= 1'b0;
    end else begin
      sentBusy_ff <= (state_ff != ST_WAIT);
      sampleReady_ff <= inStream.ready;
    end
  end

  assign sentOut = sentOut_ff;
  assign sentBusy = sentBusy_ff;
  assign initDone = initDone_ff;
  assign sampleReady = sampleReady_ff;

  // checking
  logic [15:0] lowRun_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lowRun_ff <= '0;
    end else begin
      lowRun_ff <= sentOut_ff ? 16'h0 : lowRun_ff + 16'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  idle_line_high_a: assert property (state_ff == ST_WAIT |=> sentOut_ff)
    else $error("line not high while idle");
  low_pulse_len_a: assert property ($rose(sentOut_ff) |-> lowRun_ff == 16'(LOW_CYC))
    else $error("low pulse length wrong");
  period_order_a: assert property (
    state_ff == ST_SEND && $changed(perIdx_ff) |-> perIdx_ff == $past(perIdx_ff) + 3'h1)
    else $error("period order broken");
  period_edge_a: assert property (periodEnd && perIdx_ff != `SNT_PAUSE_IDX
    |=> !sentOut_ff)
    else $error("period did not end on falling edge");
  sync_len_a: assert property (perIdx_ff == 3'h0 |-> perLen == 8'(`SNT_SYNC_TICKS) &&
    (!periodEnd || frameCnt_ff == 9'(`SNT_SYNC_TICKS - 1)))
    else $error("sync length wrong");
  nib_len_a: assert property (
    state_ff == ST_SEND && perIdx_ff == 3'h2 |-> perLen == 8'h0c + {4'h0, nib_ff[1]})
    else $error("nibble length wrong");
  frame_len_a: assert property (
    state_ff == ST_SEND && perIdx_ff == `SNT_PAUSE_IDX && periodEnd
    |-> frameCnt_ff == 9'(`SNT_FRAME_TICKS - 1) && perCnt_ff >= 8'(`SNT_LOW_TICKS))
    else $error("pause not aligned");
  crc_value_a: assert property (state_ff == ST_LOAD |=>
    nib_ff[4] == crcWord({nib_ff[1], nib_ff[2], nib_ff[3]}) && nib_ff[0] == 4'h0)
    else $error("crc or status nibble wrong");
  init_code_a: assert property (!initDone_ff |-> pushCode == 12'h000)
    else $error("init code not zero");
  init_start_a: assert property (state_ff != ST_WAIT |-> initDone_ff)
    else $error("sent before initialisation");
  dev_code_a: assert property (initDone_ff && deviceFault |-> pushCode == 12'hffb)
    else $error("device error code wrong");
  sig_code_a: assert property (
    initDone_ff && !deviceFault && signalFault |-> pushCode == 12'hffa)
    else $error("signal path code wrong");
  no_reserved_a: assert property (
    pushCode != `SNT_CODE_RSVD_LO && pushCode < 12'hffc)
    else $error("reserved code produced");

  sync_start_c: cover property (state_ff == ST_LOAD ##1 !sentOut_ff);
  pause_end_c: cover property (periodEnd && perIdx_ff == `SNT_PAUSE_IDX);
  buffer_full_c: cover property (sampleValid && !inStream.ready);
  clamp_high_c: cover property (initDone_ff && pushCode == `SNT_CODE_CLAMP_HI);
endmodule

// ==== dv/snt_rx_model.sv ====
/*
  behavioural receiver: decodes telegrams from falling-edge spacing.
  assumes TICK clock cycles per tick and a line driven from logic on clk.
*/
`timescale 1ns/10ps
module snt_rx_model #(
  parameter int TICK = 4
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic line,
  output logic [11:0] word,
  output logic [3:0] status,
  output logic crcGood,
  output int frames,
  output int badTiming
);
  logic prevLine;
  logic active;
  int cnt;
  int lowCnt;
  int frameLen;
  int idx;
  logic [3:0] nib [6];
  logic [3:0] c;

  function automatic logic [3:0] crc_step(input logic [3:0] cin, input logic [3:0] n);
    logic [3:0] r;
    r = cin;
    for (int i = 0; i < 4; i++) begin
      r = r[3] ? ({r[2:0], 1'b0} ^ 4'hd) : {r[2:0], 1'b0};
    end
    return r ^ n;
  endfunction

  always @(posedge clk) begin
    if (!resetn) begin
      prevLine = 1'b1;
      active = 1'b0;
      idx = 0;
      frames = 0;
      badTiming = 0;
    end else begin
      cnt++;
      frameLen++;
      // line idle past a whole frame: the next falling edge opens a fresh telegram
      if (line && frameLen > 282 * TICK + 1) active = 1'b0;
      if (!line) lowCnt++;
      if (!prevLine && line && lowCnt != 5 * TICK) badTiming++;
      if (prevLine && !line) begin
        if (active) begin
          if (idx == 0 && cnt != 56 * TICK) badTiming++;
          if (idx >= 1 && idx <= 5) begin
            if (cnt % TICK != 0 || cnt < 12 * TICK || cnt > 27 * TICK) badTiming++;
            nib[idx] = 4'(cnt / TICK - 12);
          end
          if (idx == 5) begin
            word = {nib[2], nib[3], nib[4]};
            status = nib[1];
            c = crc_step(crc_step(crc_step(4'h5, nib[2]), nib[3]), nib[4]);
            crcGood = (crc_step(c, 4'h0) == nib[5]);
            frames++;
          end
          if (idx == 6 && frameLen != 282 * TICK + 1) badTiming++;
        end
        idx = (active && idx < 6) ? idx + 1 : 0;
        if (idx == 0) frameLen = 0;
        cnt = 0;
        lowCnt = 1;
        active = 1'b1;
      end
      prevLine = line;
    end
  end
endmodule

// ==== dv/tb.sv ====
/*
  self-checking bench of the telegram transmitter with a receiver model.
  assumes short tick and init parameters so the run stays brief.
*/
`timescale 1ns/10ps
module tb;
  import snt_pkg::*;
  localparam int T = 4;
  localparam int INIT = 20;
  localparam snt_word_t VALS [17] = '{12'h002, 12'hff7, 12'ha5c, 12'h3c1, 12'hff8, 12'hff9,
    12'hffc, 12'hfff, 12'h000, 12'h001, 12'h100, 12'h100, 12'h100, 12'h100, 12'h100, 12'h100,
    12'h100};
  localparam logic [3:0] FLGS [17] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
    4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'hf, 4'h7, 4'h3};
  logic clk, resetn, sampleValid, deviceFault, signalFault, aboveRange, belowRange, formatSent;
  logic [11:0] outValue;
  logic sampleReady, sentOut, sentBusy, initDone, rxCrcGood;
  logic [11:0] rxWord;
  logic [3:0] rxStatus;
  int rxFrames, rxBad;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  snt_word_t expQ[$];
  snt_word_t lastCode;

  snt_tx #(.TICK_CYC(T), .INIT_CYC(INIT)) DUT (.clk(clk), .resetn(resetn), .outValue(outValue),
    .sampleValid(sampleValid), .deviceFault(deviceFault), .signalFault(signalFault),
    .aboveRange(aboveRange), .belowRange(belowRange), .formatSent(formatSent),
    .sampleReady(sampleReady), .sentOut(sentOut), .sentBusy(sentBusy), .initDone(initDone));
  snt_rx_model #(.TICK(T)) rx (.clk(clk), .resetn(resetn), .line(sentOut), .word(rxWord),
    .status(rxStatus), .crcGood(rxCrcGood), .frames(rxFrames), .badTiming(rxBad));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      error_cnt++;
      $display("[ERR] %0t run timed out", $time);
      test_done();
    end
  end

  task test_done;
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task cmp(input logic [11:0] got, input logic [11:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic snt_word_t exp_code(input logic ini, input logic [3:0] f, input snt_word_t v);
    if (!ini) return 12'h000;
    if (f[3]) return 12'hffb;
    if (f[2]) return 12'hffa;
    if (f[1] || v > 12'hff7) return 12'hff8;
    if (f[0] || v < 12'h002) return 12'h001;
    return v;
  endfunction

  task push(input snt_word_t v, input logic [3:0] f, input logic ini, input logic keep);
    @(negedge clk);
    sampleValid = 1'b1;
    outValue = v;
    {deviceFault, signalFault, aboveRange, belowRange} = f;
    if (keep) expQ.push_back(exp_code(ini, f, v));
  endtask

  task idle_in;
    @(negedge clk);
    sampleValid = 1'b0;
    {deviceFault, signalFault, aboveRange, belowRange} = 4'h0;
  endtask

  task wait_frame;
    int n;
    int k;
    n = rxFrames;
    k = 0;
    while (rxFrames == n && k < 3000) begin
      @(negedge clk);
      k++;
    end
    cmp({11'h000, rxFrames != n}, 12'h001, "telegram seen");
  endtask

  task check_frame(input snt_word_t e);
    wait_frame();
    cmp(rxWord, e, "data word");
    cmp({8'h00, rxStatus}, 12'h000, "status nibble");
    cmp({11'h000, sentBusy}, 12'h001, "busy in telegram");
    cmp({11'h000, rxCrcGood}, 12'h001, "checksum");
  endtask

  task check_idle(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      cmp({10'h000, sentOut, sentBusy}, 12'h002, "idle line");
    end
  endtask

  task t_init;
    repeat (5) @(negedge clk);
    cmp({9'h000, sentOut, sentBusy, initDone}, 12'h004, "reset outputs");
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    push(12'h5a5, 4'h0, 1'b0, 1'b1);
    idle_in();
    for (int k = 0; k < INIT - 5; k++) begin
      @(negedge clk);
      cmp({10'h000, sentOut, initDone}, 12'h002, "line during init");
    end
    check_frame(expQ.pop_front());
    formatSent = 1'b0;
    repeat (300 * T) @(negedge clk);
    check_idle(100);
  endtask

  task t_fill;
    cmp({11'h000, sampleReady}, 12'h001, "buffer free");
    for (int i = 0; i < 32; i++) begin
      if (i < 17) push(VALS[i], FLGS[i], 1'b1, 1'b1);
      else push(snt_word_t'(12'h040 + i * 12'h093), 4'h0, 1'b1, 1'b1);
    end
    push(12'h777, 4'h0, 1'b1, 1'b0);
    push(12'h777, 4'h0, 1'b1, 1'b0);
    idle_in();
    repeat (2) @(negedge clk);
    cmp({11'h000, sampleReady}, 12'h000, "buffer full");
    lastCode = expQ[expQ.size() - 1];
  endtask

  task t_drain;
    formatSent = 1'b1;
    for (int i = 0; i < 32; i++) begin
      check_frame(expQ.pop_front());
    end
    check_frame(lastCode);
    formatSent = 1'b0;
    cmp({11'h000, sampleReady}, 12'h001, "buffer drained");
    repeat (300 * T) @(negedge clk);
    check_idle(50);
    cmp(12'(rxBad), 12'h000, "period timing");
  endtask

  initial begin
    resetn = 1'b0;
    formatSent = 1'b1;
    sampleValid = 1'b0;
    outValue = 12'h000;
    {deviceFault, signalFault, aboveRange, belowRange} = 4'h0;
    t_init();
    t_fill();
    t_drain();
    test_done();
  end
endmodule
